/* design/thg_pkg.sv */
// shared constants and carrier types for the health-gated random source
package thg_pkg;

  // ---------------------------------------------------------------
  // word sizes and test figures
  // ---------------------------------------------------------------
  localparam int unsigned WORD_MAX      = 16;  // widest output word
  localparam int unsigned BYTE_W        = 8;   // narrow output word
  localparam int unsigned TF_RUN_LEN    = 64;  // equal raw bits = dead
  localparam int unsigned OT_WIN_LEN    = 256; // raw bits per online window
  localparam int unsigned OT_ONES_LO    = 96;  // least ones in a window
  localparam int unsigned OT_ONES_HI    = 160; // most ones in a window
  localparam int unsigned CNT_W         = 9;   // counter width
  localparam logic [15:0] WORD_RST      = 16'h0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        valid; // word available
    logic [15:0] data;  // low 8 bits only in byte mode
  } thg_word_t;

  typedef struct packed {
    logic tot_fail;     // total failure seen
    logic ot_fail;      // online test defect seen
    logic rep_fail;     // repeated block seen
    logic startup_ok;   // power-up online test passed
  } thg_status_t;

  typedef enum logic [3:0] {
    ST_STARTUP = 4'b0001,
    ST_RUN     = 4'b0010,
    ST_HALT    = 4'b0100,
    ST_SPARE   = 4'b1000
  } thg_state_t;

endpackage : thg_pkg

/* design/thg_prev_mem.sv */
// holds the previously formed block for the repeat comparison
`timescale 1ns/100ps
module thg_prev_mem #(
  parameter int unsigned W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         en,
  input  wire logic         wr,
  input  wire logic [W-1:0] wdata,
  output logic              have,
  output logic      [W-1:0] rdata
);

  typedef struct packed {
    logic         have;
    logic [W-1:0] word;
  } thg_mem_t;

  thg_mem_t s_q;
  thg_mem_t s_d;

  // ---------------------------------------------------------------
  // store one block
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (wr) begin
      s_d.have = 1'b1;
      s_d.word = wdata;
    end
  end

  // register the state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else if (en) begin
      s_q <= s_d;
    end
  end

  assign have  = s_q.have;
  assign rdata = s_q.word;

endmodule : thg_prev_mem

/* design/thg_gate.sv */
// health tests and output gate around the raw entropy bit stream
`timescale 1ns/100ps
module thg_gate
  import thg_pkg::*;
#(
  parameter int unsigned RUN_LEN = thg_pkg::TF_RUN_LEN,
  parameter int unsigned WIN_LEN = thg_pkg::OT_WIN_LEN,
  parameter int unsigned ONES_LO = thg_pkg::OT_ONES_LO,
  parameter int unsigned ONES_HI = thg_pkg::OT_ONES_HI
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         ce,
  input  wire logic         raw_bit,
  input  wire logic         raw_valid,
  input  wire logic         wide_mode,
  input  wire logic         word_ack,
  output thg_pkg::thg_word_t   word_out,
  output thg_pkg::thg_status_t status_out
);
  import thg_pkg::*;

  typedef struct packed {
    thg_state_t  st;
    logic [CNT_W-1:0] run_cnt;  // equal bits after the first in current run
    logic        last_bit;
    logic        have_last;
    logic [CNT_W-1:0] win_cnt;  // bits seen in window
    logic [CNT_W-1:0] ones_cnt; // ones seen in window
    logic [15:0] shreg;         // block under assembly
    logic [4:0]  fill;          // bits in shreg
    thg_word_t   word;
    thg_status_t stat;
  } thg_regs_t;

  thg_regs_t s_q;
  thg_regs_t s_d;
  logic        prev_have;
  logic [15:0] prev_word;
  logic        blk_done;
  logic [15:0] blk_word;

  // width of a block in the current mode
  function automatic logic [4:0] blk_len(input logic wide);
    blk_len = wide ? 5'(WORD_MAX) : 5'(BYTE_W);
  endfunction : blk_len

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [15:0] nxt_sh;
    logic        tf_hit;
    logic        ot_end;
    logic        ot_bad;
    nxt_sh   = {s_q.shreg[14:0], raw_bit};
    tf_hit   = 1'b0;
    ot_end   = 1'b0;
    ot_bad   = 1'b0;
    blk_done = 1'b0;
    blk_word = nxt_sh;
    s_d      = s_q;
    if (word_ack) begin
      s_d.word.valid = 1'b0;
    end
    if (raw_valid && (s_q.st != ST_HALT)) begin
      if (s_q.have_last && raw_bit == s_q.last_bit) begin
        s_d.run_cnt = s_q.run_cnt + 1'b1;
        tf_hit = (s_q.run_cnt + 1'b1) >= CNT_W'(RUN_LEN - 1);
      end else begin
        s_d.run_cnt = '0;
      end
      s_d.last_bit  = raw_bit;
      s_d.have_last = 1'b1;
      s_d.win_cnt  = s_q.win_cnt + 1'b1;
      s_d.ones_cnt = s_q.ones_cnt + CNT_W'(raw_bit);
      if (s_q.win_cnt == CNT_W'(WIN_LEN - 1)) begin
        ot_end = 1'b1;
        ot_bad = (s_d.ones_cnt < CNT_W'(ONES_LO)) ||
                 (s_d.ones_cnt > CNT_W'(ONES_HI));
        s_d.win_cnt  = '0;
        s_d.ones_cnt = '0;
      end
      // raw bits kept unmixed, judged offline
      s_d.shreg = nxt_sh;
      s_d.fill  = s_q.fill + 5'd1;
      if (s_d.fill == blk_len(wide_mode)) begin
        s_d.fill = '0;
        blk_done = 1'b1;
        if (!wide_mode) begin
          blk_word = {8'h00, nxt_sh[7:0]};
        end
      end
      if (tf_hit) begin
        s_d.stat.tot_fail = 1'b1;
      end
      if (ot_bad) begin
        s_d.stat.ot_fail = 1'b1;
      end
      if (blk_done && prev_have && blk_word == prev_word) begin
        s_d.stat.rep_fail = 1'b1;
      end
      if (ot_end && !ot_bad && s_q.st == ST_STARTUP) begin
        s_d.stat.startup_ok = 1'b1;
      end
      if (s_d.stat.tot_fail || s_d.stat.ot_fail || s_d.stat.rep_fail) begin
        s_d.st         = ST_HALT;
        s_d.word.valid = 1'b0;
      end else begin
        case (s_q.st)
          ST_STARTUP: begin
            if (s_d.stat.startup_ok) begin
              s_d.st = ST_RUN;
            end
          end
          ST_RUN: begin
            if (blk_done) begin
              s_d.word.valid = 1'b1;
              s_d.word.data  = blk_word;
            end
          end
          default: begin
            s_d.st = ST_HALT;
          end
        endcase
      end
    end
    if (s_q.st == ST_HALT) begin
      s_d.word.valid = 1'b0;
    end
  end

  // register all state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q    <= '0;
      s_q.st <= ST_STARTUP;
      s_q.word.data <= WORD_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  thg_prev_mem #(
    .W (WORD_MAX)
  ) u_prev (
    .clk   (clk),
    .rstn  (rstn),
    .en    (ce),
    .wr    (blk_done && raw_valid && s_q.st != ST_HALT),
    .wdata (blk_word),
    .have  (prev_have),
    .rdata (prev_word)
  );

  assign word_out   = s_q.word;
  assign status_out = s_q.stat;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic any_fail;
  assign any_fail = s_q.stat.tot_fail | s_q.stat.ot_fail | s_q.stat.rep_fail;

  chk_no_word_dead: assert property (@(posedge clk) disable iff (!rstn)
    s_q.stat.tot_fail |-> !s_q.word.valid)
    else $error("word valid after total failure");
  chk_startup_gate: assert property (@(posedge clk) disable iff (!rstn)
    !s_q.stat.startup_ok |-> !s_q.word.valid)
    else $error("word valid before startup pass");
  chk_online_block: assert property (@(posedge clk) disable iff (!rstn)
    s_q.stat.ot_fail |-> !s_q.word.valid)
    else $error("word valid after online defect");
  chk_sticky_flags: assert property (@(posedge clk) disable iff (!rstn)
    $rose(any_fail) |=> any_fail [*8])
    else $error("failure flag dropped");
  // a set failure flag means the machine is halted in the same cycle
  chk_fail_halt: assert property (@(posedge clk) disable iff (!rstn)
    any_fail |-> s_q.st == ST_HALT)
    else $error("not halted on failure");
  chk_byte_width: assert property (@(posedge clk) disable iff (!rstn)
    (ce && blk_done && !wide_mode && s_q.st == ST_RUN && !s_d.stat.rep_fail
     && !s_d.stat.tot_fail && !s_d.stat.ot_fail)
    |=> s_q.word.data[15:8] == 8'h00)
    else $error("byte word has upper bits");
  chk_repeat_drop: assert property (@(posedge clk) disable iff (!rstn)
    (ce && raw_valid && blk_done && prev_have && blk_word == prev_word
     && s_q.st != ST_HALT) |=> s_q.stat.rep_fail && !s_q.word.valid)
    else $error("repeated block released");
  chk_stuck_flag: assert property (@(posedge clk) disable iff (!rstn)
    (ce && raw_valid && s_q.st != ST_HALT && s_q.have_last
     && raw_bit == s_q.last_bit && s_q.run_cnt == CNT_W'(RUN_LEN - 2))
    |=> s_q.stat.tot_fail)
    else $error("stuck source not flagged");

  cov_startup_pass: cover property (@(posedge clk) disable iff (!rstn)
    $rose(s_q.stat.startup_ok));
  cov_word_out: cover property (@(posedge clk) disable iff (!rstn)
    s_q.word.valid && wide_mode);
  cov_dead_src: cover property (@(posedge clk) disable iff (!rstn)
    $rose(s_q.stat.tot_fail));
  cov_repeat: cover property (@(posedge clk) disable iff (!rstn)
    $rose(s_q.stat.rep_fail));

endmodule : thg_gate

/* sim/thg_reader.sv */
// reader model that fetches words from the gated random source
`timescale 1ns/100ps
module thg_reader
  import thg_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rstn,
  input  thg_pkg::thg_word_t word,
  input  wire logic [1:0]    lag,
  output logic               ack_q,
  output logic [15:0]        last_q,
  output logic [7:0]         got_q
);
  logic [1:0] wait_q;

  // acks each word after lag cycles, keeping a copy and a count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q  <= 1'b0;
      wait_q <= 2'h0;
      got_q  <= 8'h00;
      last_q <= 16'h0000;
    end else if (ack_q) begin
      ack_q <= 1'b0; // one-cycle pulse
    end else if (word.valid) begin
      if (wait_q == lag) begin
        ack_q  <= 1'b1;
        last_q <= word.data;
        got_q  <= got_q + 8'h01;
        wait_q <= 2'h0;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : thg_reader

/* sim/thg_gate_tb_top.sv */
// self-checking bench for the health-gated random word output
`timescale 1ns/100ps
module thg_gate_tb_top;
  import thg_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        raw_bit = 1'b0;
  logic        raw_valid = 1'b0;
  logic        ce = 1'b1;
  logic        wide_mode = 1'b0;
  logic [1:0]  lag = 2'h0;
  logic        ack_q;
  logic [15:0] last_q;
  logic [7:0]  got_q;
  thg_word_t   word_out;
  thg_status_t status_out;
  int          fail_count = 0;
  int          tests_run = 0;

  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end

  thg_gate #(.RUN_LEN(8), .WIN_LEN(16), .ONES_LO(4), .ONES_HI(12)) DUT (
    .clk(clk), .rstn(rstn), .ce(ce), .raw_bit(raw_bit),
    .raw_valid(raw_valid), .wide_mode(wide_mode), .word_ack(ack_q),
    .word_out(word_out), .status_out(status_out));

  thg_reader reader (.clk(clk), .rstn(rstn), .word(word_out), .lag(lag),
    .ack_q(ack_q), .last_q(last_q), .got_q(got_q));

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit

  // n bits of v, most significant first, one per cycle
  task automatic feed(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge clk);
      raw_bit = v[i];
      raw_valid = 1'b1;
    end
    @(negedge clk);
    raw_valid = 1'b0;
    raw_bit = ~raw_bit; // line not qualified: no stale value
    repeat (6) @(negedge clk);
  endtask : feed

  // reset for 8 cycles, then the 16-bit power-up window
  task automatic do_reset(input logic [15:0] win);
    rstn = 1'b0;
    wide_mode = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    feed(win, 16);
  endtask : do_reset

  task automatic t_start();
    do_reset(16'h5A3C);
    chk_word({8'h00, got_q}, 16'h0000);
    chk_bit(status_out.startup_ok, 1'b1);
    // frozen block: a stuck byte must neither count nor release
    ce = 1'b0;
    feed(16'h00FF, 8);
    ce = 1'b1;
    chk_bit(status_out.tot_fail, 1'b0);
    chk_word({8'h00, got_q}, 16'h0000);
  endtask : t_start

  task automatic t_words();
    lag = 2'h3;
    feed(16'h0096, 8);
    chk_word(last_q, 16'h0096);
    wide_mode = 1'b1;
    feed(16'hC3A5, 16);
    chk_word(last_q, 16'hC3A5);
    feed(16'hC3A5, 16);
    chk_bit(status_out.rep_fail, 1'b1);
    chk_word({8'h00, got_q}, 16'h0002);
    feed(16'h6996, 16);
    chk_word({8'h00, got_q}, 16'h0002);
  endtask : t_words

  task automatic t_dead();
    lag = 2'h0;
    do_reset(16'h5A3C);
    feed(16'h0096, 8);
    feed(16'h0000, 8);
    chk_bit(status_out.tot_fail, 1'b1);
    chk_word({8'h00, got_q}, 16'h0001);
    feed(16'h0069, 8);
    chk_word({8'h00, got_q}, 16'h0001);
  endtask : t_dead

  task automatic t_defect();
    logic [7:0] seen;
    do_reset(16'h5A3C);
    feed(16'h00FE, 8);
    feed(16'h00FD, 8);
    seen = got_q;
    chk_bit(status_out.ot_fail, 1'b1);
    feed(16'h0096, 8);
    chk_word({8'h00, got_q}, {8'h00, seen});
    chk_bit(status_out.ot_fail, 1'b1);
  endtask : t_defect

  task automatic t_bad_start();
    do_reset(16'h0102);
    chk_bit(status_out.ot_fail, 1'b1);
    chk_bit(status_out.startup_ok, 1'b0);
    feed(16'h0096, 8);
    feed(16'h0069, 8);
    chk_word({8'h00, got_q}, 16'h0000);
  endtask : t_bad_start

  task automatic results();
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    t_start();
    t_words();
    t_dead();
    t_defect();
    t_bad_start();
    results();
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    results();
  end
endmodule : thg_gate_tb_top
